// File: epts_defines.svh
// Purpose: Constants for the event processor thread scheduler.
// Assumes: Six threads, sixteen events per thread.
// Notes: Included by the package and the design.
`ifndef EPTS_DEFINES_SVH
`define EPTS_DEFINES_SVH
`define EPTS_NTHR 6
`define EPTS_NEVT 16
`define EPTS_TIME_W 12
`define EPTS_PSC_W 8
`define EPTS_GRP_NONE 2'h0
`define EPTS_GRP_C 2'h1
`define EPTS_GRP_B 2'h2
`define EPTS_GRP_A 2'h3
`define EPTS_EVT_OPAMP_ON 4'hc
`define EPTS_EVT_OPAMP_OFF 4'hd
`define EPTS_EVT_CPU_INT 4'he
`define EPTS_EVT_RSVD 4'hf
`endif

// File: epts_pkg.sv
// Purpose: Types for the event processor thread scheduler.
// Assumes: Constants come from epts_defines.svh.
// Notes: Only the state encodings are numbered here.
`include "epts_defines.svh"
package epts_pkg;
    typedef enum logic [1:0] {
        EPTS_RUN = 2'b00,
        EPTS_TWAIT = 2'b01,
        EPTS_EWAIT = 2'b10
    } epts_state_t;
    typedef logic [`EPTS_NTHR-1:0] epts_mask_t;
endpackage : epts_pkg

// File: epts_sched.sv
// Purpose: Thread enable, wait, event latching and scheduling for six threads.
// Assumes: The execution core issues op strobes only for the granted thread.
// Notes: One system clock; all outputs are registered.
// Behaviour
// - Enabled thread becomes eligible and runs once granted.
// - Clearing enable stops the thread after its current instruction.
// - Disabled thread pauses its countdown and holds its prescaler.
// - Disabled thread latches no events into pending bits.
// - Disabling withdraws the thread's execution request.
// - Disabling keeps any established wait suspension.
// - Thread reset clears its state and prescaler only.
// - Thread reset while enabled ends any pending wait.
// - Each cycle pick a requester, low number first, no switch cost.
// - Group code 00 none, 11 group A, 10 group B.
// - Round robin inside a group; chosen thread drops to lowest.
// - Final winner by thread number among group winners and ungrouped.
// - Timed or event wait drops the thread's request.
// - No requesters means no instruction is issued.
// - Wait ends at countdown zero or on the awaited event.
// - Event accepted when thread enabled and accept mask bit set.
// - Consumed awaited event clears its pending bit on resume.
// - A set in the clearing cycle wins over the clear.
// - Level event keeps pending set while high, even after an event wait consumes it.
// - Emit lines 0-1 PWM, 2-9 ADC, 10-11 output gate.
// - Emit 12 opamp on, 13 opamp off, 14 CPU interrupt, 15 unused.
// - Event wait with pending already set continues and clears the bit.
// - Timed wait loads countdown; zero waits until the next tick.
`timescale 1ns/1ps
`default_nettype none
`include "epts_defines.svh"
module epts_sched (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`EPTS_NTHR-1:0] thread_en,
    input wire logic [`EPTS_NTHR-1:0] thread_rst,
    input wire logic [2*`EPTS_NTHR-1:0] priority_group_sel,
    input wire logic [`EPTS_PSC_W*`EPTS_NTHR-1:0] psc_period,
    input wire logic [`EPTS_NEVT*`EPTS_NTHR-1:0] event_accept_mask,
    input wire logic [`EPTS_NEVT*`EPTS_NTHR-1:0] event_in,
    input wire logic timed_suspend_op,
    input wire logic event_suspend_op,
    input wire logic event_emit_op,
    input wire logic [`EPTS_TIME_W-1:0] op_time,
    input wire logic [3:0] op_event,
    output logic [`EPTS_NTHR-1:0] grant_r,
    output logic issue_r,
    output logic [`EPTS_NTHR-1:0] thread_request_r,
    output logic [2*`EPTS_NTHR-1:0] thread_state_field_r,
    output logic [`EPTS_NEVT*`EPTS_NTHR-1:0] event_pending_r,
    output logic [1:0] pwm_retrig_r,
    output logic [7:0] adc_trig_r,
    output logic [1:0] pwm_output_gate_r,
    output logic opamp_enable_evt_r,
    output logic opamp_disable_evt_r,
    output logic cpu_int_r
);
    localparam int N = `EPTS_NTHR;
    localparam int NE = `EPTS_NEVT;

    epts_pkg::epts_state_t st_r [N];
    logic [`EPTS_TIME_W-1:0] time_r [N];
    logic [`EPTS_PSC_W-1:0] psc_r [N];
    logic [3:0] wevt_r [N];
    logic [N-1:0] tick;
    logic [N-1:0] req;
    logic [N-1:0] win;
    logic [2:0] ptr_r [3];
    logic [N-1:0] cand;
    logic emit_go;

    // Rotating pick: first requester at or after the pointer.
    function automatic logic [N-1:0] rr_pick(input logic [N-1:0] r,
                                             input logic [2:0] p);
        logic [N-1:0] o;
        int k;
        o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            k = (int'(p) + i) % N;
            if (r[k]) begin
                o = '0;
                o[k] = 1'b1;
            end
        end
        return o;
    endfunction : rr_pick

    function automatic logic [N-1:0] fixed_pick(input logic [N-1:0] r);
        return r & ~(r - 1'b1);
    endfunction : fixed_pick

    function automatic logic [2:0] idx_of(input logic [N-1:0] oh);
        logic [2:0] v;
        v = 3'h0;
        for (int i = 0; i < N; i++) begin
            if (oh[i]) begin
                v = 3'(i);
            end
        end
        return v;
    endfunction : idx_of

    function automatic logic [N-1:0] grp_members(input logic [1:0] code,
            input logic [2*N-1:0] sel);
        logic [N-1:0] m;
        for (int i = 0; i < N; i++) begin
            m[i] = (sel[2*i +: 2] == code);
        end
        return m;
    endfunction : grp_members

    // A thread asks for the core only while enabled and not waiting.
    genvar t;
    generate
        for (t = 0; t < N; t++) begin : g_thr
            assign req[t] = thread_en[t] && !thread_rst[t]
                && st_r[t] == epts_pkg::EPTS_RUN;
            assign tick[t] = thread_en[t]
                && psc_r[t] == psc_period[`EPTS_PSC_W*t +: `EPTS_PSC_W];

            // Prescaler halts while disabled and restarts on thread reset.
            always_ff @(posedge sys_clk) begin
                if (!nrst || thread_rst[t]) begin
                    psc_r[t] <= '0;
                end else if (thread_en[t]) begin
                    psc_r[t] <= tick[t] ? '0 : psc_r[t] + 1'b1;
                end
            end

            // Wait state machine; wait ops apply to the granted thread.
            always_ff @(posedge sys_clk) begin
                if (!nrst || thread_rst[t]) begin
                    st_r[t] <= epts_pkg::EPTS_RUN;
                    time_r[t] <= '0;
                    wevt_r[t] <= 4'h0;
                end else begin
                    case (st_r[t])
                        epts_pkg::EPTS_RUN: begin
                            if (grant_r[t] && timed_suspend_op) begin
                                st_r[t] <= epts_pkg::EPTS_TWAIT;
                                time_r[t] <= op_time;
                            end else if (grant_r[t] && event_suspend_op
                                    && !event_pending_r[NE*t + op_event]) begin
                                st_r[t] <= epts_pkg::EPTS_EWAIT;
                                wevt_r[t] <= op_event;
                            end
                        end
                        epts_pkg::EPTS_TWAIT: begin
                            // Countdown pauses while disabled; state kept.
                            if (tick[t]) begin
                                if (time_r[t] == '0) begin
                                    st_r[t] <= epts_pkg::EPTS_RUN;
                                end else begin
                                    time_r[t] <= time_r[t] - 1'b1;
                                end
                            end
                        end
                        epts_pkg::EPTS_EWAIT: begin
                            if (event_pending_r[NE*t + wevt_r[t]]) begin
                                st_r[t] <= epts_pkg::EPTS_RUN;
                            end
                        end
                        default: begin
                            st_r[t] <= epts_pkg::EPTS_RUN;
                        end
                    endcase
                end
            end

            assign thread_state_field_r[2*t +: 2] = st_r[t];

            // Pending bits: accepted events set, consumption clears, set wins.
            for (genvar e = 0; e < NE; e++) begin : g_evt
                logic set_e;
                logic clr_e;
                assign set_e = thread_en[t] && event_in[NE*t + e]
                    && event_accept_mask[NE*t + e];
                assign clr_e = (st_r[t] == epts_pkg::EPTS_EWAIT
                        && wevt_r[t] == 4'(e))
                    || (st_r[t] == epts_pkg::EPTS_RUN && grant_r[t]
                        && event_suspend_op && op_event == 4'(e));
                always_ff @(posedge sys_clk) begin
                    if (!nrst) begin
                        event_pending_r[NE*t + e] <= 1'b0;
                    end else if (set_e) begin
                        event_pending_r[NE*t + e] <= 1'b1;
                    end else if (clr_e && event_pending_r[NE*t + e]) begin
                        event_pending_r[NE*t + e] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Group winners plus ungrouped requesters, then fixed priority.
    always_comb begin
        cand = req & grp_members(`EPTS_GRP_NONE, priority_group_sel);
        for (int g = 0; g < 3; g++) begin
            cand = cand | rr_pick(req & grp_members(2'(g + 1),
                priority_group_sel), ptr_r[g]);
        end
        win = fixed_pick(cand);
    end

    // Pointer moves past the winner only when its group won.
    generate
        for (t = 0; t < 3; t++) begin : g_ptr
            logic [N-1:0] mem;
            assign mem = grp_members(2'(t + 1), priority_group_sel);
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    ptr_r[t] <= 3'h0;
                end else if (|(win & mem)) begin
                    ptr_r[t] <= (idx_of(win) == 3'(N - 1)) ? 3'h0
                        : idx_of(win) + 3'h1;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            grant_r <= '0;
            issue_r <= 1'b0;
            thread_request_r <= '0;
        end else begin
            grant_r <= win;
            issue_r <= |win;
            thread_request_r <= req;
        end
    end

    // Emitted events are one-cycle pulses from the granted thread.
    assign emit_go = event_emit_op && |grant_r;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pwm_retrig_r <= '0;
            adc_trig_r <= '0;
            pwm_output_gate_r <= '0;
            opamp_enable_evt_r <= 1'b0;
            opamp_disable_evt_r <= 1'b0;
            cpu_int_r <= 1'b0;
        end else begin
            pwm_retrig_r <= '0;
            adc_trig_r <= '0;
            pwm_output_gate_r <= '0;
            if (emit_go && op_event < 4'h2) begin
                pwm_retrig_r[op_event[0]] <= 1'b1;
            end
            if (emit_go && op_event >= 4'h2 && op_event < 4'ha) begin
                adc_trig_r[3'(op_event - 4'h2)] <= 1'b1;
            end
            if (emit_go && (op_event == 4'ha || op_event == 4'hb)) begin
                pwm_output_gate_r[op_event[0]] <= 1'b1;
            end
            opamp_enable_evt_r <= emit_go
                && op_event == `EPTS_EVT_OPAMP_ON;
            opamp_disable_evt_r <= emit_go
                && op_event == `EPTS_EVT_OPAMP_OFF;
            cpu_int_r <= emit_go && op_event == `EPTS_EVT_CPU_INT;
        end
    end

    a_no_req_no_issue: assert property (@(posedge sys_clk) disable iff (!nrst)
        req == '0 |=> !issue_r) else $error("issue with no request");
    a_grant_onehot: assert property (@(posedge sys_clk) disable iff (!nrst)
        $onehot0(grant_r)) else $error("grant not one-hot");
    a_grant_requested: assert property (@(posedge sys_clk) disable iff (!nrst)
        |win |=> (grant_r & thread_request_r) != '0)
        else $error("grant to non-requester");
    a_low_first: assert property (@(posedge sys_clk) disable iff (!nrst)
        (priority_group_sel == '0 && req[0]) |=> grant_r[0])
        else $error("thread 0 not first");
    a_disabled_noreq: assert property (@(posedge sys_clk) disable iff (!nrst)
        !thread_en[0] |-> !req[0]) else $error("disabled thread requests");
    a_wait_drops: assert property (@(posedge sys_clk) disable iff (!nrst)
        (grant_r[0] && timed_suspend_op && !thread_rst[0]) |=> !req[0])
        else $error("wait kept request");
    a_rst_ends_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
        thread_rst[0] |=> st_r[0] == epts_pkg::EPTS_RUN)
        else $error("reset left wait");
    a_set_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
        (thread_en[0] && event_in[7] && event_accept_mask[7])
        |=> event_pending_r[7]) else $error("set lost");
    a_cpu_int: assert property (@(posedge sys_clk) disable iff (!nrst)
        (event_emit_op && |grant_r && op_event == 4'he) |=> cpu_int_r)
        else $error("no cpu interrupt");
    c_idle: cover property (@(posedge sys_clk) issue_r ##1 !issue_r);
    c_twait: cover property (@(posedge sys_clk)
        st_r[0] == epts_pkg::EPTS_TWAIT ##[1:50] st_r[0] == epts_pkg::EPTS_RUN);
    c_ewait: cover property (@(posedge sys_clk)
        st_r[1] == epts_pkg::EPTS_EWAIT);
endmodule : epts_sched
`default_nettype wire

// File: epts_core_model.sv
// Purpose: Execution core model that sends one op at a time to the scheduler.
// Assumes: The bench queues an op with cmd_go and waits while busy is high.
// Notes: Op fields carry inverted junk whenever no op is strobed.
`timescale 1ns/1ps
`default_nettype none
`include "epts_defines.svh"
module epts_core_model #(
    parameter int THR = 0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`EPTS_NTHR-1:0] grant_r,
    input wire logic cmd_go,
    input wire logic [1:0] cmd_kind,
    input wire logic [`EPTS_TIME_W-1:0] cmd_time,
    input wire logic [3:0] cmd_evt,
    output logic busy,
    output logic timed_suspend_op,
    output logic event_suspend_op,
    output logic event_emit_op,
    output logic [`EPTS_TIME_W-1:0] op_time,
    output logic [3:0] op_event
);
    logic [1:0] kind_r;
    logic [`EPTS_TIME_W-1:0] time_r;
    logic [3:0] evt_r;
    logic fire;
    // An op is only strobed while the scheduler grants our thread.
    assign fire = busy && grant_r[THR];
    assign timed_suspend_op = fire && kind_r == 2'h1;
    assign event_suspend_op = fire && kind_r == 2'h2;
    assign event_emit_op = fire && kind_r == 2'h3;
    assign op_time = fire ? time_r : ~time_r;
    assign op_event = fire ? evt_r : ~evt_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else if (cmd_go) begin
            busy <= 1'b1;
            kind_r <= cmd_kind;
            time_r <= cmd_time;
            evt_r <= cmd_evt;
        end else if (fire) begin
            busy <= 1'b0;
        end
    end
endmodule : epts_core_model
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the thread scheduler.
// Assumes: Thread 0 carries all ops; prescaler period 3 unless noted.
// Notes: Waits are bounded; a hang ends in the closing report.
`timescale 1ns/1ps
`default_nettype none
`include "epts_defines.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] thread_en = '0;
    logic [5:0] thread_rst = '0;
    logic [11:0] priority_group_sel = '0;
    logic [47:0] psc_period = {6{8'h03}};
    logic [95:0] event_accept_mask = 96'h00a0;
    logic [95:0] event_in = '0;
    logic cmd_go = 1'b0;
    logic [1:0] cmd_kind = '0;
    logic [11:0] cmd_time = '0;
    logic [3:0] cmd_evt = '0;
    logic busy, tso, eso, eeo, issue_r, cpu_int_r, amp_on, amp_off;
    logic [11:0] op_time, thread_state_field_r;
    logic [3:0] op_event;
    logic [5:0] grant_r, thread_request_r;
    logic [95:0] event_pending_r;
    logic [1:0] pwm_retrig_r, pwm_output_gate_r;
    logic [7:0] adc_trig_r;
    logic [15:0] emit_vec;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    assign emit_vec = {1'b0, cpu_int_r, amp_off, amp_on, pwm_output_gate_r,
                       adc_trig_r, pwm_retrig_r};
    epts_sched uut (.sys_clk(sys_clk), .nrst(nrst), .thread_en(thread_en),
        .thread_rst(thread_rst), .priority_group_sel(priority_group_sel),
        .psc_period(psc_period), .event_accept_mask(event_accept_mask),
        .event_in(event_in), .timed_suspend_op(tso), .event_suspend_op(eso),
        .event_emit_op(eeo), .op_time(op_time), .op_event(op_event),
        .grant_r(grant_r), .issue_r(issue_r),
        .thread_request_r(thread_request_r),
        .thread_state_field_r(thread_state_field_r),
        .event_pending_r(event_pending_r), .pwm_retrig_r(pwm_retrig_r),
        .adc_trig_r(adc_trig_r), .pwm_output_gate_r(pwm_output_gate_r),
        .opamp_enable_evt_r(amp_on), .opamp_disable_evt_r(amp_off),
        .cpu_int_r(cpu_int_r));
    epts_core_model core (.sys_clk(sys_clk), .nrst(nrst), .grant_r(grant_r),
        .cmd_go(cmd_go), .cmd_kind(cmd_kind), .cmd_time(cmd_time),
        .cmd_evt(cmd_evt), .busy(busy), .timed_suspend_op(tso),
        .event_suspend_op(eso), .event_emit_op(eeo), .op_time(op_time),
        .op_event(op_event));
    always #5 sys_clk = ~sys_clk;
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic op(input logic [1:0] k, input logic [11:0] t,
                      input logic [3:0] e);
        int i;
        @(posedge sys_clk);
        cmd_go <= 1'b1;
        cmd_kind <= k;
        cmd_time <= t;
        cmd_evt <= e;
        cyc(1);
        cmd_go <= 1'b0;
        for (i = 0; i < 40 && busy !== 1'b0; i++) cyc(1);
        check(busy, 1'b0);
    endtask : op
    task automatic wait_st(input logic [1:0] s, input int mx, output int n);
        n = 0;
        while (thread_state_field_r[1:0] !== s && n < mx) begin
            cyc(1);
            n++;
        end
        check(thread_state_field_r[1:0], s);
    endtask : wait_st
    task automatic s_sched;
        logic [5:0] g;
        logic [1:0] k;
        check({grant_r, issue_r, thread_request_r}, '0);
        thread_en <= 6'h14;
        cyc(4);
        check({grant_r, issue_r}, {6'h04, 1'b1});
        thread_en <= 6'h00;
        cyc(4);
        check({issue_r, thread_request_r}, '0);
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            priority_group_sel <= {6{k}};
            thread_en <= 6'h0e;
            cyc(4);
            repeat (6) begin
                g = grant_r;
                cyc(1);
                check(grant_r, (k == 2'h0 || g == 6'h08) ? 6'h02 : g << 1);
            end
        end
        priority_group_sel <= 12'hffc;
        thread_en <= 6'h0f;
        cyc(4);
        check(grant_r, 6'h01);
        priority_group_sel <= '0;
        thread_en <= 6'h01;
        cyc(3);
    endtask : s_sched
    task automatic s_timed;
        int n;
        op(2'h1, 12'h005, 4'h0);
        wait_st(epts_pkg::EPTS_TWAIT, 5, n);
        cyc(1);
        check(issue_r, 1'b0);
        wait_st(epts_pkg::EPTS_RUN, 60, n);
        check(n >= 10, 1'b1);
        op(2'h1, 12'h000, 4'h0);
        wait_st(epts_pkg::EPTS_TWAIT, 5, n);
        op(2'h1, 12'h00a, 4'h0);
        wait_st(epts_pkg::EPTS_TWAIT, 5, n);
        thread_en <= 6'h00;
        cyc(80);
        check(thread_state_field_r[1:0], epts_pkg::EPTS_TWAIT);
        thread_en <= 6'h01;
        wait_st(epts_pkg::EPTS_RUN, 80, n);
        op(2'h1, 12'hfff, 4'h0);
        wait_st(epts_pkg::EPTS_TWAIT, 5, n);
        thread_rst <= 6'h01;
        cyc(1);
        thread_rst <= 6'h00;
        wait_st(epts_pkg::EPTS_RUN, 4, n);
    endtask : s_timed
    task automatic s_events;
        int n;
        event_in <= 96'h0060;
        cyc(1);
        event_in <= '0;
        cyc(3);
        check(event_pending_r, 96'h0020);
        op(2'h2, 12'h000, 4'h5);
        cyc(2);
        check({thread_state_field_r[1:0], event_pending_r}, '0);
        op(2'h2, 12'h000, 4'h7);
        wait_st(epts_pkg::EPTS_EWAIT, 5, n);
        event_in <= 96'h0080;
        wait_st(epts_pkg::EPTS_RUN, 6, n);
        cyc(3);
        check(event_pending_r, 96'h0080);
        event_in <= '0;
        cyc(3);
        check(event_pending_r, 96'h0080);
    endtask : s_events
    task automatic s_emit;
        logic [15:0] seen;
        for (int e = 0; e < 16; e++) begin
            op(2'h3, 12'h000, 4'(e));
            seen = '0;
            repeat (3) begin
                seen |= emit_vec;
                cyc(1);
            end
            check(seen, (e == 15) ? 16'h0000 : 16'h0001 << e);
        end
    endtask : s_emit
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        cyc(2);
        s_sched();
        s_timed();
        s_events();
        s_emit();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
